/* File: logic/dtp_defs.vh */
`ifndef DTP_DEFS_VH
`define DTP_DEFS_VH

// Mode configuration byte layout
`define DTP_INIT_BIT 0
`define DTP_DBUF_BIT 1
`define DTP_OPMODE_LO 2
`define DTP_OPMODE_HI 3
`define DTP_EVENT_BIT 4
`define DTP_CLKSEL_LO 5
`define DTP_CLKSEL_HI 7

// Operating mode codes
`define DTP_OP_PPG 2'h2

// Reset values
`define DTP_MODE_RESET 16'h0000
`define DTP_CMP_RESET 16'hFFFF
`define DTP_COUNT_CLEAR 16'h0000
`define DTP_BYTE_CLEAR 8'h00
`define DTP_DIV_CLEAR 11'h000

// Source clock divider masks, tick when masked count is all ones
`define DTP_DIV_SEL0 11'h7FF
`define DTP_DIV_SEL1 11'h3FF
`define DTP_DIV_SEL2 11'h0FF
`define DTP_DIV_SEL3 11'h03F
`define DTP_DIV_SEL4 11'h00F
`define DTP_DIV_SEL5 11'h003
`define DTP_DIV_SEL6 11'h001
`define DTP_DIV_SEL7 11'h000

`endif

/* File: logic/dtp_prescaler.v */
`timescale 1ns/10ps
`include "dtp_defs.vh"

module dtp_prescaler (
    input wire clock,
    input wire resetn,
    input wire clear,
    input wire [2:0] clkSel,
    output reg tick
);

reg [10:0] divCount;

function [10:0] divMask;
    input [2:0] sel;
    begin
        case (sel)
            3'h0: divMask = `DTP_DIV_SEL0;
            3'h1: divMask = `DTP_DIV_SEL1;
            3'h2: divMask = `DTP_DIV_SEL2;
            3'h3: divMask = `DTP_DIV_SEL3;
            3'h4: divMask = `DTP_DIV_SEL4;
            3'h5: divMask = `DTP_DIV_SEL5;
            3'h6: divMask = `DTP_DIV_SEL6;
            default: divMask = `DTP_DIV_SEL7;
        endcase
    end
endfunction

// Held clear while stopped so the first tick after a start is a full period
always @(posedge clock) begin
    if (!resetn || clear) begin
        divCount <= `DTP_DIV_CLEAR;
        tick <= 1'b0;
    end else begin
        divCount <= divCount + 11'h001;
        tick <= ((divCount & divMask(clkSel)) == divMask(clkSel));
    end
end

endmodule // dtp_prescaler

/* File: logic/dtp_timer.v */
`timescale 1ns/10ps
`include "dtp_defs.vh"

module dtp_timer (
    input wire clock,
    input wire resetn,
    input wire runFirst,
    input wire runSecond,
    input wire cascadeSel,
    input wire outputAndSel,
    input wire modeWrFirst,
    input wire modeWrSecond,
    input wire cycleLoWr,
    input wire cycleHiWr,
    input wire dutyFirstWr,
    input wire dutySecondWr,
    input wire [7:0] wrData,
    output wire [7:0] modeReadFirst,
    output wire [7:0] modeReadSecond,
    output wire [7:0] cycleLoRead,
    output wire [7:0] cycleHiRead,
    output wire [7:0] dutyFirstRead,
    output wire [7:0] dutySecondRead,
    output wire pulseOutFirst,
    output wire pulseOutSecond,
    output reg combinedOut,
    output wire irqFirst,
    output wire irqSecond
);

reg [15:0] modeCfg;
reg [15:0] cycleBuf;
reg [15:0] cycleAct;
reg [15:0] dutyBuf;
reg [15:0] dutyAct;
reg [15:0] wideBuf;
reg [15:0] count;
reg [1:0] pulseOut;
reg [1:0] irq;

reg [15:0] next_modeCfg;
reg [15:0] next_cycleBuf;
reg [15:0] next_cycleAct;
reg [15:0] next_dutyBuf;
reg [15:0] next_dutyAct;
reg [15:0] next_wideBuf;
reg [15:0] next_count;
reg [1:0] next_pulseOut;
reg [1:0] next_irq;

wire [1:0] run = {runSecond, runFirst};
wire [1:0] modeWr = {modeWrSecond, modeWrFirst};
wire [1:0] cycleWr = {cycleHiWr, cycleLoWr};
wire [1:0] dutyWr = {dutySecondWr, dutyFirstWr};
wire [1:0] tick;
wire [7:0] cfgSecond = modeCfg[15:8];

function isPpg;
    input [7:0] cfg;
    input casc;
    begin
        isPpg = (cfg[`DTP_OPMODE_HI:`DTP_OPMODE_LO] == `DTP_OP_PPG)
            && !cfg[`DTP_EVENT_BIT] && !casc;
    end
endfunction

// 16-bit timer mode wants second channel mode 00 or 01 and event select 0
wire wideMode = cascadeSel && !cfgSecond[`DTP_OPMODE_HI] && !cfgSecond[`DTP_EVENT_BIT];
wire wideHold = cfgSecond[`DTP_DBUF_BIT] && runSecond;

dtp_prescaler firstDivider (
    .clock(clock),
    .resetn(resetn),
    .clear(!runFirst),
    .clkSel(modeCfg[`DTP_CLKSEL_HI:`DTP_CLKSEL_LO]),
    .tick(tick[0])
);

dtp_prescaler secondDivider (
    .clock(clock),
    .resetn(resetn),
    .clear(!runSecond),
    .clkSel(cfgSecond[`DTP_CLKSEL_HI:`DTP_CLKSEL_LO]),
    .tick(tick[1])
);

integer ch;

always @* begin
    next_modeCfg = modeCfg;
    next_cycleBuf = cycleBuf;
    next_cycleAct = cycleAct;
    next_dutyBuf = dutyBuf;
    next_dutyAct = dutyAct;
    next_wideBuf = wideBuf;
    next_count = count;
    next_pulseOut = pulseOut;
    next_irq = 2'h0;

    // Counting first, so a write in the same cycle still lands on top
    for (ch = 0; ch < 2; ch = ch + 1) begin
        if (isPpg(modeCfg[ch*8 +: 8], cascadeSel)) begin
            if (!run[ch]) begin
                next_count[ch*8 +: 8] = `DTP_BYTE_CLEAR;
                next_pulseOut[ch] = modeCfg[ch*8 + `DTP_INIT_BIT];
            end else if (tick[ch] && count[ch*8 +: 8] == cycleAct[ch*8 +: 8]) begin
                next_pulseOut[ch] = modeCfg[ch*8 + `DTP_INIT_BIT];
                next_irq[ch] = 1'b1;
                next_count[ch*8 +: 8] = `DTP_BYTE_CLEAR;
                if (modeCfg[ch*8 + `DTP_DBUF_BIT]) begin
                    next_cycleAct[ch*8 +: 8] = cycleBuf[ch*8 +: 8];
                    next_dutyAct[ch*8 +: 8] = dutyBuf[ch*8 +: 8];
                end
            end else begin
                // Level compare, so a value written equal to the count acts at once
                if (count[ch*8 +: 8] == dutyAct[ch*8 +: 8]) begin
                    next_pulseOut[ch] = !modeCfg[ch*8 + `DTP_INIT_BIT];
                end
                if (tick[ch]) begin
                    next_count[ch*8 +: 8] = count[ch*8 +: 8] + 8'h01;
                end
            end
        end else if (!wideMode) begin
            next_count[ch*8 +: 8] = `DTP_BYTE_CLEAR;
            next_pulseOut[ch] = modeCfg[ch*8 + `DTP_INIT_BIT];
        end else begin
            next_pulseOut[ch] = modeCfg[ch*8 + `DTP_INIT_BIT];
        end
    end

    if (wideMode) begin
        if (!runSecond) begin
            next_count = `DTP_COUNT_CLEAR;
        end else if (tick[1]) begin
            // Exact equality only: a lower compare is passed and met after wrap
            if (count == cycleAct) begin
                next_count = `DTP_COUNT_CLEAR;
                next_irq[1] = 1'b1;
                if (cfgSecond[`DTP_DBUF_BIT]) begin
                    next_cycleAct = wideBuf;
                end
            end else begin
                next_count = count + 16'h0001;
            end
        end
    end

    for (ch = 0; ch < 2; ch = ch + 1) begin
        // Refused while running; in 16-bit mode either run bit locks both
        if (modeWr[ch] && !run[ch] && !(wideMode && run != 2'h0)) begin
            next_modeCfg[ch*8 +: 8] = wrData;
        end
        if (dutyWr[ch]) begin
            next_dutyBuf[ch*8 +: 8] = wrData;
            if (!(modeCfg[ch*8 + `DTP_DBUF_BIT] && run[ch])) begin
                next_dutyAct[ch*8 +: 8] = wrData;
            end
        end
        if (cycleWr[ch] && !wideMode) begin
            next_cycleBuf[ch*8 +: 8] = wrData;
            if (!(modeCfg[ch*8 + `DTP_DBUF_BIT] && run[ch])) begin
                next_cycleAct[ch*8 +: 8] = wrData;
            end
        end
    end

    // Byte pairs: the low byte waits; the high byte write moves the pair
    if (wideMode && cycleLoWr) begin
        next_cycleBuf[7:0] = wrData;
    end
    if (wideMode && cycleHiWr) begin
        next_cycleBuf[15:8] = wrData;
        next_wideBuf = {wrData, cycleBuf[7:0]};
        if (!wideHold) begin
            next_cycleAct = {wrData, cycleBuf[7:0]};
        end
    end
end

always @(posedge clock) begin
    if (!resetn) begin
        modeCfg <= `DTP_MODE_RESET;
        cycleBuf <= `DTP_CMP_RESET;
        cycleAct <= `DTP_CMP_RESET;
        dutyBuf <= `DTP_CMP_RESET;
        dutyAct <= `DTP_CMP_RESET;
        wideBuf <= `DTP_CMP_RESET;
        count <= `DTP_COUNT_CLEAR;
        pulseOut <= 2'h0;
        irq <= 2'h0;
        combinedOut <= 1'b0;
    end else begin
        modeCfg <= next_modeCfg;
        cycleBuf <= next_cycleBuf;
        cycleAct <= next_cycleAct;
        dutyBuf <= next_dutyBuf;
        dutyAct <= next_dutyAct;
        wideBuf <= next_wideBuf;
        count <= next_count;
        pulseOut <= next_pulseOut;
        irq <= next_irq;
        // Without the AND select the pin follows the second channel
        combinedOut <= outputAndSel ? (next_pulseOut[0] & next_pulseOut[1])
            : next_pulseOut[1];
    end
end

assign modeReadFirst = modeCfg[7:0];
assign modeReadSecond = modeCfg[15:8];
assign cycleLoRead = cycleBuf[7:0];
assign cycleHiRead = cycleBuf[15:8];
assign dutyFirstRead = dutyBuf[7:0];
assign dutySecondRead = dutyBuf[15:8];
assign pulseOutFirst = pulseOut[0];
assign pulseOutSecond = pulseOut[1];
assign irqFirst = irq[0];
assign irqSecond = irq[1];

endmodule // dtp_timer

/* File: sim/dtp_timer_sva.sv */
`timescale 1ns/10ps
module dtp_timer_chk (
    input wire clock,
    input wire resetn,
    input wire runFirst,
    input wire runSecond,
    input wire cascadeSel,
    input wire outputAndSel,
    input wire modeWrFirst,
    input wire cycleLoWr,
    input wire dutyFirstWr,
    input wire [7:0] wrData,
    input wire [7:0] modeReadFirst,
    input wire [7:0] cycleLoRead,
    input wire [7:0] dutyFirstRead,
    input wire pulseOutFirst,
    input wire pulseOutSecond,
    input wire combinedOut,
    input wire irqFirst,
    input wire irqSecond
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Mode write in the stop cycle is excluded, the idle level may follow either byte
    sequence s_run_drop;
        runFirst ##1 (!runFirst && !modeWrFirst);
    endsequence
    a_stop_idle: assert property (s_run_drop |=> pulseOutFirst == modeReadFirst[0])
        else $error("pin not idle after stop");
    a_idle_level: assert property ($past(!runFirst && !modeWrFirst) |->
        pulseOutFirst == modeReadFirst[0]) else $error("stopped pin not idle");
    a_and_follow: assert property ($past(outputAndSel) |->
        combinedOut == (pulseOutFirst & pulseOutSecond)) else $error("bad AND output");
    a_irq_level: assert property (irqFirst |-> pulseOutFirst == modeReadFirst[0])
        else $error("pin not back at interrupt");
    a_irq_run: assert property (irqFirst |-> $past(runFirst) && !$past(cascadeSel))
        else $error("interrupt while stopped");
    a_irq_casc: assert property (irqSecond |-> $past(runSecond))
        else $error("second interrupt while stopped");
    a_mode_lock: assert property ($past(runFirst && modeWrFirst) |-> $stable(modeReadFirst))
        else $error("mode changed while running");
    a_cycle_read: assert property ($past(cycleLoWr) |-> cycleLoRead == $past(wrData))
        else $error("cycle read not last write");
    a_duty_read: assert property ($past(dutyFirstWr) |-> dutyFirstRead == $past(wrData))
        else $error("duty read not last write");
endmodule // dtp_timer_chk

bind dtp_timer dtp_timer_chk u_chk (.clock(clock), .resetn(resetn), .runFirst(runFirst),
    .runSecond(runSecond), .cascadeSel(cascadeSel), .outputAndSel(outputAndSel),
    .modeWrFirst(modeWrFirst), .cycleLoWr(cycleLoWr), .dutyFirstWr(dutyFirstWr),
    .wrData(wrData), .modeReadFirst(modeReadFirst), .cycleLoRead(cycleLoRead),
    .dutyFirstRead(dutyFirstRead), .pulseOutFirst(pulseOutFirst),
    .pulseOutSecond(pulseOutSecond), .combinedOut(combinedOut), .irqFirst(irqFirst),
    .irqSecond(irqSecond));

/* File: sim/dtp_pulse_sink.sv */
`timescale 1ns/10ps
// Receiver of a pulse pin: cycles high and period between interrupt marks
module dtp_pulse_sink (
    input wire clock,
    input wire pulse,
    input wire mark,
    output int highCount,
    output int period
);
    int h = 0;
    int p = 0;
    always @(posedge clock) begin
        if (mark) begin
            highCount <= h;
            period <= p;
            h <= int'(pulse);
            p <= 1;
        end else begin
            h <= h + int'(pulse);
            p <= p + 1;
        end
    end
endmodule // dtp_pulse_sink

/* File: sim/dtp_timer_tb.sv */
`timescale 1ns/10ps
module dtp_timer_tb;
    logic clock = 0, resetn = 0, cascadeSel = 0, outputAndSel = 0;
    logic [1:0] run = 0;
    logic [5:0] wrs = 0;
    logic [7:0] wrData = 0;
    wire [7:0] modeRd [0:1], cycRd [0:1], dutyRd [0:1];
    wire [1:0] pulse, irq;
    wire combinedOut;
    int per [0:1], hi [0:1];
    int errors = 0, n_compared = 0, c, i, db, cyc, duty;
    always #20 clock = ~clock;
    dtp_timer u_dut (.clock(clock), .resetn(resetn), .runFirst(run[0]), .runSecond(run[1]),
        .cascadeSel(cascadeSel), .outputAndSel(outputAndSel), .modeWrFirst(wrs[0]),
        .modeWrSecond(wrs[1]), .cycleLoWr(wrs[2]), .cycleHiWr(wrs[3]), .dutyFirstWr(wrs[4]),
        .dutySecondWr(wrs[5]), .wrData(wrData), .modeReadFirst(modeRd[0]),
        .modeReadSecond(modeRd[1]), .cycleLoRead(cycRd[0]), .cycleHiRead(cycRd[1]),
        .dutyFirstRead(dutyRd[0]), .dutySecondRead(dutyRd[1]), .pulseOutFirst(pulse[0]),
        .pulseOutSecond(pulse[1]), .combinedOut(combinedOut), .irqFirst(irq[0]),
        .irqSecond(irq[1]));
    dtp_pulse_sink u_sink0 (.clock(clock), .pulse(pulse[0]), .mark(irq[0]),
        .highCount(hi[0]), .period(per[0]));
    dtp_pulse_sink u_sink1 (.clock(clock), .pulse(pulse[1]), .mark(irq[1]),
        .highCount(hi[1]), .period(per[1]));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input int w, input logic [7:0] d);
        @(posedge clock);
        #1 wrs[w] = 1'b1;
        wrData = d;
        @(posedge clock);
        #1 wrs = 6'h00;
    endtask
    // Bounded wait; returns once the sink has latched the finished period
    task waitIrq(input int ch);
        i = 0;
        do begin
            @(posedge clock);
            #1 i++;
        end while (irq[ch] !== 1'b1 && i < 3000);
        if (i >= 3000) errors++;
        @(posedge clock);
        #1;
    endtask
    task conclude;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude;
    end
    initial begin
        void'($urandom(94));
        repeat (2) @(posedge clock);
        #1 resetn = 1'b1;
        for (c = 0; c < 2; c++) for (db = 0; db < 2; db++) begin
            cyc = $urandom_range(20, 6);
            duty = $urandom_range(cyc - 1, 1);
            outputAndSel = 1'($urandom_range(1, 0));
            wr(c, 8'(8'hE8 | db));
            wr(2 + c, 8'(cyc));
            wr(4 + c, 8'(duty));
            check(modeRd[c], 8'(8'hE8 | db));
            check(dutyRd[c], 8'(duty));
            run[c] = 1'b1;
            waitIrq(c);
            waitIrq(c);
            check(per[c], cyc + 1);
            check(hi[c], db ? duty + 1 : cyc - duty);
            check(combinedOut, outputAndSel ? (pulse[0] & pulse[1]) : pulse[1]);
            wr(c, 8'h00);
            check(modeRd[c], 8'(8'hE8 | db));
            run[c] = 1'b0;
            @(posedge clock);
            #1;
            check(pulse[c], db);
        end
        for (db = 0; db < 2; db++) begin
            wr(0, 8'(8'hE8 | (db << 1)));
            wr(2, 8'h0A);
            run[0] = 1'b1;
            waitIrq(0);
            waitIrq(0);
            check(per[0], 11);
            wr(2, 8'h10);
            check(cycRd[0], 8'h10);
            waitIrq(0);
            check(per[0], db ? 11 : 17);
            waitIrq(0);
            check(per[0], 17);
            run[0] = 1'b0;
        end
        cascadeSel = 1'b1;
        cyc = $urandom_range(600, 300);
        wr(1, 8'hE2);
        wr(2, 8'(cyc));
        wr(3, 8'(cyc >> 8));
        check(cycRd[1], 8'(cyc >> 8));
        run[1] = 1'b1;
        waitIrq(1);
        waitIrq(1);
        check(per[1], cyc + 1);
        wr(1, 8'h00);
        check(modeRd[1], 8'hE2);
        check(pulse, 2'b00);
        wr(2, 8'h20);
        wr(3, 8'h00);
        waitIrq(1);
        check(per[1], cyc + 1);
        waitIrq(1);
        check(per[1], 33);
        run[1] = 1'b0;
        conclude;
    end
endmodule // dtp_timer_tb
